// *** logic/anrs_pkg.sv ***
// package: register indices, field positions, reset values and masks
// assumes: 16-bit management words reached by a 5-bit register index
package anrs_pkg;
	// ==========================================================
	// widths
	localparam int DATA_W = 16;
	localparam int ADDR_W = 5;
	localparam int EVT_W  = 4;
	localparam int STRAP_W = 3;

	// ==========================================================
	// register indices
	localparam logic [ADDR_W-1:0] IDX_ADVERT    = 5'h04;
	localparam logic [ADDR_W-1:0] IDX_PARTNER   = 5'h05;
	localparam logic [ADDR_W-1:0] IDX_EXPANSION = 5'h06;
	localparam logic [ADDR_W-1:0] IDX_CONTROL   = 5'h10;
	localparam logic [ADDR_W-1:0] IDX_IRQ_STAT  = 5'h11;
	localparam logic [ADDR_W-1:0] IDX_IRQ_MASK  = 5'h12;

	// ==========================================================
	// code word fields (advertisement and partner share the layout)
	localparam int BIT_NEXT_PAGE = 15;
	localparam int BIT_ACK       = 14;
	localparam int BIT_RFAULT    = 13;
	localparam int BIT_PAUSE_ASM = 11;
	localparam int BIT_PAUSE_SYM = 10;
	localparam int BIT_100FD     = 8;
	localparam int BIT_100HD     = 7;
	localparam int BIT_10FD      = 6;
	localparam int BIT_10HD      = 5;
	localparam int SEL_W         = 5;
	localparam logic [SEL_W-1:0] SELECTOR_8023 = 5'h01;
	localparam logic [DATA_W-1:0] ADVERT_WR_MASK = 16'h2dff;
	localparam logic [DATA_W-1:0] ADVERT_RESET   = 16'h0081;

	// ==========================================================
	// expansion fields
	localparam int BIT_PD_FAULT   = 4;
	localparam int BIT_LP_NP_ABLE = 3;
	localparam int BIT_NP_ABLE    = 2;
	localparam int BIT_PAGE_RX    = 1;
	localparam int BIT_LP_AN_ABLE = 0;

	// ==========================================================
	// control fields
	localparam int BIT_SOFT_RST  = 15;
	localparam int BIT_MAN_SPEED = 13;
	localparam int BIT_AN_EN     = 12;
	localparam int BIT_RESTART   = 9;
	localparam int BIT_MAN_DUPLX = 8;

	// ==========================================================
	// interrupt events
	localparam int EVT_PAGE_RX  = 0;
	localparam int EVT_PD_FAULT = 1;
	localparam int EVT_AN_DONE  = 2;
	localparam int EVT_RFAULT   = 3;

	// ==========================================================
	// straps: bit order 100 full, 10 full, 10 half
	localparam int STRAP_100FD = 2;
	localparam int STRAP_10FD  = 1;
	localparam int STRAP_10HD  = 0;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	typedef enum logic [1:0] {
		ANRS_PAUSE_NONE,
		ANRS_PAUSE_SYM,
		ANRS_PAUSE_ASYM
	} anrs_pause_type;
endpackage : anrs_pkg

// *** logic/anrs_sync.sv ***
// file: three-stage synchroniser for slow pin levels
// assumes: inputs are quasi-static; output follows once stages two and three agree
`timescale 1ns/10ps
module anrs_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level_out
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			level_out <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					level_out[i] <= s3_q[i];
				end
			end
		end
	end
endmodule : anrs_sync

// *** logic/anrs_flag.sv ***
// file: bank of sticky flags, set wins over clear
// assumes: set and clear come from logic on the same clock
`timescale 1ns/10ps
module anrs_flag #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic [WIDTH-1:0] set_in,
	input  wire logic [WIDTH-1:0] clr_in,
	output logic      [WIDTH-1:0] flag_out
);
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flag_out <= '0;
		end else begin
			flag_out <= set_in | (flag_out & ~clr_in);
		end
	end
endmodule : anrs_flag

// *** logic/anrs_regs.sv ***
// file: auto-negotiation register set with pause and speed resolution
// assumes: partner word, fault and completion come from the arbiter on MCLK_IN
//
// What this block does
// - advertisement register at index 4; bits 15:14, 12, 9 reserved
// - pause field 11:10 resets to 00; none, sym, asym, both
// - with both pause kinds advertised, resolve to at most one
// - advertised remote fault bit 13 resets to 0
// - bit 7 resets to 1; bits 8, 6, 5 reset from straps
// - selector 00001; writable in advertisement, read-only in partner
// - partner word at index 5, cleared except selector; bit 14 acknowledge
// - partner bit 15 reads 0, no next page exchange
// - expansion bit 2 reads 0, no local next page
// - partner bit 9 reads 0, no four-pair support
// - partner bit 10 pause flag; bits 8:5 partner abilities
// - expansion bit 4 latches parallel detection fault, resets 0
// - expansion bit 1 latches page received, resets 0
// - expansion bit 3 partner next page, bit 0 partner able; read-only
// - advertisement used only while enabled; negotiation overrides manual speed
// - restart bit written by software, cleared by the device
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
module anrs_regs (
	input  wire logic                          MCLK_IN,
	input  wire logic                          RST_N_IN,
	input  wire logic [anrs_pkg::ADDR_W-1:0]   ADDR_IN,
	input  wire logic [anrs_pkg::DATA_W-1:0]   WDATA_IN,
	input  wire logic                          WR_IN,
	input  wire logic                          RD_IN,
	output logic      [anrs_pkg::DATA_W-1:0]   RDATA_OUT,
	input  wire logic [anrs_pkg::STRAP_W-1:0]  MODE_STRAP_IN,
	input  wire logic [anrs_pkg::DATA_W-1:0]   PARTNER_WORD_IN,
	input  wire logic                          PARTNER_VALID_IN,
	input  wire logic                          PD_FAULT_IN,
	input  wire logic                          AN_COMPLETE_IN,
	output logic      [anrs_pkg::DATA_W-1:0]   ADVERT_WORD_OUT,
	output logic                               AN_ENABLE_OUT,
	output logic                               AN_RESTART_OUT,
	output logic                               SPEED_100_OUT,
	output logic                               FULL_DUPLEX_OUT,
	output anrs_pkg::anrs_pause_type           PAUSE_MODE_OUT,
	output logic                               IRQ_OUT
);
	import anrs_pkg::*;

	// ==========================================================
	// declarations
	logic [DATA_W-1:0]  advert_q;
	logic [DATA_W-1:0]  partner_q;
	logic               lp_np_q;
	logic               lp_able_q;
	logic               an_en_q;
	logic               restart_q;
	logic               soft_rst_q;
	logic               man_speed_q;
	logic               man_duplex_q;
	logic [EVT_W-1:0]   irq_mask_q;
	logic [EVT_W-1:0]   irq_stat;
	logic [EVT_W-1:0]   evt_set;
	logic [EVT_W-1:0]   evt_clr;
	logic [1:0]         lh_flags;
	logic [1:0]         lh_set;
	logic [1:0]         lh_clr;
	logic               an_done_prev_q;
	logic [STRAP_W-1:0] strap_lvl;
	logic [1:0]         strap_wait_q;
	logic               strap_done_q;
	logic               strap_load_q;
	logic               strap_load;
	logic               wr_advert;
	logic               wr_control;
	logic               rd_expansion;
	logic               an_active;
	logic [DATA_W-1:0]  rd_mux;
	logic [DATA_W-1:0]  expansion_word;
	logic [DATA_W-1:0]  partner_word;
	logic [DATA_W-1:0]  control_word;
	logic [DATA_W-1:0]  common;

	// ==========================================================
	// strap capture after reset release
	anrs_sync #(
		.WIDTH(STRAP_W)
	) u_strap_sync (
		.clk_in   (MCLK_IN),
		.rst_n_in (RST_N_IN),
		.pin_in   (MODE_STRAP_IN),
		.level_out(strap_lvl)
	);

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			strap_wait_q <= '0;
			strap_done_q <= 1'b0;
		end else if (!strap_done_q) begin
			if (strap_wait_q == STRAP_SETTLE) begin
				strap_done_q <= 1'b1;
			end else begin
				strap_wait_q <= strap_wait_q + 2'h1;
			end
		end
	end

	// load one edge after the count ends: the synchronised level only settles on that edge
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			strap_load_q <= 1'b0;
		end else begin
			strap_load_q <= !strap_done_q && strap_wait_q == STRAP_SETTLE;
		end
	end

	// straps reload once after hardware reset and on every soft reset
	assign strap_load = strap_load_q || soft_rst_q;

	// ==========================================================
	// bus decode
	assign wr_advert    = WR_IN && ADDR_IN == IDX_ADVERT;
	assign wr_control   = WR_IN && ADDR_IN == IDX_CONTROL;
	assign rd_expansion = RD_IN && ADDR_IN == IDX_EXPANSION;

	// ==========================================================
	// advertisement register
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			advert_q <= ADVERT_RESET;
		end else if (strap_load) begin
			advert_q                <= ADVERT_RESET;
			advert_q[BIT_100FD]     <= strap_lvl[STRAP_100FD];
			advert_q[BIT_10FD]      <= strap_lvl[STRAP_10FD];
			advert_q[BIT_10HD]      <= strap_lvl[STRAP_10HD];
		end else if (wr_advert) begin
			advert_q <= WDATA_IN & ADVERT_WR_MASK;
		end
	end

	// advertised word reaches the arbiter only while negotiation is on
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ADVERT_WORD_OUT <= '0;
		end else begin
			ADVERT_WORD_OUT <= an_en_q ? advert_q : '0;
		end
	end

	// ==========================================================
	// partner ability word
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			partner_q <= '0;
			lp_np_q   <= 1'b0;
			lp_able_q <= 1'b0;
		end else if (soft_rst_q || restart_q) begin
			partner_q <= '0;
			lp_np_q   <= 1'b0;
			lp_able_q <= 1'b0;
		end else if (PARTNER_VALID_IN) begin
			partner_q                <= '0;
			partner_q[BIT_ACK]       <= 1'b1;
			partner_q[BIT_RFAULT]    <= PARTNER_WORD_IN[BIT_RFAULT];
			partner_q[BIT_PAUSE_SYM] <= PARTNER_WORD_IN[BIT_PAUSE_SYM];
			partner_q[BIT_100FD]     <= PARTNER_WORD_IN[BIT_100FD];
			partner_q[BIT_100HD]     <= PARTNER_WORD_IN[BIT_100HD];
			partner_q[BIT_10FD]      <= PARTNER_WORD_IN[BIT_10FD];
			partner_q[BIT_10HD]      <= PARTNER_WORD_IN[BIT_10HD];
			lp_np_q                  <= PARTNER_WORD_IN[BIT_NEXT_PAGE];
			lp_able_q                <= 1'b1;
		end
	end

	always_comb begin
		partner_word                       = partner_q;
		partner_word[BIT_NEXT_PAGE]        = 1'b0;
		partner_word[BIT_PAUSE_SYM-1]      = 1'b0;
		partner_word[SEL_W-1:0]            = SELECTOR_8023;
	end

	// ==========================================================
	// expansion latching flags
	assign lh_set = {PD_FAULT_IN, PARTNER_VALID_IN};
	assign lh_clr = {2{rd_expansion || soft_rst_q || restart_q}};

	anrs_flag #(
		.WIDTH(2)
	) u_lh_flags (
		.clk_in  (MCLK_IN),
		.rst_n_in(RST_N_IN),
		.set_in  (lh_set),
		.clr_in  (lh_clr),
		.flag_out(lh_flags)
	);

	always_comb begin
		expansion_word                 = '0;
		expansion_word[BIT_PD_FAULT]   = lh_flags[1];
		expansion_word[BIT_LP_NP_ABLE] = lp_np_q;
		expansion_word[BIT_NP_ABLE]    = 1'b0;
		expansion_word[BIT_PAGE_RX]    = lh_flags[0];
		expansion_word[BIT_LP_AN_ABLE] = lp_able_q;
	end

	// ==========================================================
	// control register
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			an_en_q      <= 1'b1;
			man_speed_q  <= 1'b1;
			man_duplex_q <= 1'b1;
		end else if (soft_rst_q) begin
			an_en_q      <= 1'b1;
			man_speed_q  <= 1'b1;
			man_duplex_q <= 1'b1;
		end else if (wr_control) begin
			an_en_q      <= WDATA_IN[BIT_AN_EN];
			man_speed_q  <= WDATA_IN[BIT_MAN_SPEED];
			man_duplex_q <= WDATA_IN[BIT_MAN_DUPLX];
		end
	end

	// restart and soft reset clear themselves one cycle after the write
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			restart_q  <= 1'b0;
			soft_rst_q <= 1'b0;
		end else begin
			restart_q  <= wr_control && WDATA_IN[BIT_RESTART];
			soft_rst_q <= wr_control && WDATA_IN[BIT_SOFT_RST];
		end
	end

	assign AN_RESTART_OUT = restart_q;
	assign AN_ENABLE_OUT  = an_en_q;

	always_comb begin
		control_word                = '0;
		control_word[BIT_SOFT_RST]  = soft_rst_q;
		control_word[BIT_MAN_SPEED] = man_speed_q;
		control_word[BIT_AN_EN]     = an_en_q;
		control_word[BIT_RESTART]   = restart_q;
		control_word[BIT_MAN_DUPLX] = man_duplex_q;
	end

	// ==========================================================
	// resolution of speed, duplex and pause
	assign an_active = an_en_q && AN_COMPLETE_IN;
	assign common    = advert_q & partner_q;

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			SPEED_100_OUT   <= 1'b0;
			FULL_DUPLEX_OUT <= 1'b0;
		end else if (!an_en_q) begin
			SPEED_100_OUT   <= man_speed_q;
			FULL_DUPLEX_OUT <= man_duplex_q;
		end else if (AN_COMPLETE_IN) begin
			// highest common mode wins over the manual selection
			SPEED_100_OUT   <= common[BIT_100FD] || common[BIT_100HD];
			FULL_DUPLEX_OUT <= common[BIT_100FD] ||
				(!common[BIT_100HD] && common[BIT_10FD]);
		end
	end

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			PAUSE_MODE_OUT <= ANRS_PAUSE_NONE;
		end else if (!an_active) begin
			PAUSE_MODE_OUT <= ANRS_PAUSE_NONE;
		end else if (advert_q[BIT_PAUSE_SYM] && partner_q[BIT_PAUSE_SYM]) begin
			PAUSE_MODE_OUT <= ANRS_PAUSE_SYM;
		end else if (advert_q[BIT_PAUSE_ASM]) begin
			PAUSE_MODE_OUT <= ANRS_PAUSE_ASYM;
		end else begin
			PAUSE_MODE_OUT <= ANRS_PAUSE_NONE;
		end
	end

	// ==========================================================
	// interrupt status and mask
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			an_done_prev_q <= 1'b0;
		end else begin
			an_done_prev_q <= AN_COMPLETE_IN;
		end
	end

	always_comb begin
		evt_set               = '0;
		evt_set[EVT_PAGE_RX]  = PARTNER_VALID_IN;
		evt_set[EVT_PD_FAULT] = PD_FAULT_IN;
		evt_set[EVT_AN_DONE]  = AN_COMPLETE_IN && !an_done_prev_q;
		evt_set[EVT_RFAULT]   = PARTNER_VALID_IN && PARTNER_WORD_IN[BIT_RFAULT];
	end

	// write one to clear; a new event in the same cycle wins
	assign evt_clr = (WR_IN && ADDR_IN == IDX_IRQ_STAT) ? WDATA_IN[EVT_W-1:0] : '0;

	anrs_flag #(
		.WIDTH(EVT_W)
	) u_irq_flags (
		.clk_in  (MCLK_IN),
		.rst_n_in(RST_N_IN),
		.set_in  (evt_set),
		.clr_in  (evt_clr),
		.flag_out(irq_stat)
	);

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			irq_mask_q <= '0;
		end else if (WR_IN && ADDR_IN == IDX_IRQ_MASK) begin
			irq_mask_q <= WDATA_IN[EVT_W-1:0];
		end
	end

	assign IRQ_OUT = |(irq_stat & irq_mask_q);

	// ==========================================================
	// read path: data stands one cycle after the strobe, zero otherwise
	always_comb begin
		case (ADDR_IN)
			IDX_ADVERT: begin
				rd_mux = advert_q;
			end
			IDX_PARTNER: begin
				rd_mux = partner_word;
			end
			IDX_EXPANSION: begin
				rd_mux = expansion_word;
			end
			IDX_CONTROL: begin
				rd_mux = control_word;
			end
			IDX_IRQ_STAT: begin
				rd_mux = {{(DATA_W-EVT_W){1'b0}}, irq_stat};
			end
			IDX_IRQ_MASK: begin
				rd_mux = {{(DATA_W-EVT_W){1'b0}}, irq_mask_q};
			end
			default: begin
				rd_mux = '0;
			end
		endcase
	end

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			RDATA_OUT <= '0;
		end else begin
			RDATA_OUT <= RD_IN ? rd_mux : '0;
		end
	end
endmodule : anrs_regs

// *** tb/anrs_regs_assertions.sv ***
// checker: concurrent properties on the register set's top ports
// assumes: bound into anrs_regs; one clock, async active-low reset
`timescale 1ns/10ps
module anrs_regs_assertions (
	input wire logic                        MCLK_IN,
	input wire logic                        RST_N_IN,
	input wire logic [anrs_pkg::ADDR_W-1:0] ADDR_IN,
	input wire logic [anrs_pkg::DATA_W-1:0] WDATA_IN,
	input wire logic                        WR_IN,
	input wire logic                        RD_IN,
	input wire logic [anrs_pkg::DATA_W-1:0] RDATA_OUT,
	input wire logic                        PARTNER_VALID_IN,
	input wire logic                        PD_FAULT_IN,
	input wire logic                        AN_COMPLETE_IN,
	input wire logic [anrs_pkg::DATA_W-1:0] ADVERT_WORD_OUT,
	input wire logic                        AN_ENABLE_OUT,
	input wire logic                        AN_RESTART_OUT,
	input wire anrs_pkg::anrs_pause_type    PAUSE_MODE_OUT
);
	import anrs_pkg::*;
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!RST_N_IN);
	// ==========================================================
	// decoded reads
	wire logic rd_adv = RD_IN && (ADDR_IN == IDX_ADVERT);
	wire logic rd_lp  = RD_IN && (ADDR_IN == IDX_PARTNER);
	wire logic rd_exp = RD_IN && (ADDR_IN == IDX_EXPANSION);
	wire logic quiet  = !PD_FAULT_IN && !PARTNER_VALID_IN;
	// ==========================================================
	// properties
	chk_advert_rsvd: assert property (rd_adv |=> (RDATA_OUT & 16'hd200) == 16'h0000)
		else $error("advert reserved bits set");
	chk_partner_fixed: assert property (rd_lp |=> !RDATA_OUT[15] && !RDATA_OUT[9]
		&& RDATA_OUT[4:0] == SELECTOR_8023) else $error("partner fixed bits wrong");
	chk_exp_fixed: assert property (rd_exp |=> (RDATA_OUT & 16'hffe4) == 16'h0000)
		else $error("expansion fixed bits set");
	chk_ack_seen: assert property (PARTNER_VALID_IN ##2 rd_lp |=> RDATA_OUT[14])
		else $error("acknowledge missing after page");
	chk_page_latch: assert property (PARTNER_VALID_IN ##4 rd_exp |=> RDATA_OUT[1])
		else $error("page received flag missing");
	chk_pd_latch: assert property (PD_FAULT_IN ##2 rd_exp |=> RDATA_OUT[4])
		else $error("parallel fault flag missing");
	chk_latch_clear: assert property (rd_exp && quiet ##1 quiet ##1 rd_exp && quiet
		|=> !RDATA_OUT[4] && !RDATA_OUT[1]) else $error("latched flags kept after read");
	chk_restart_pulse: assert property (WR_IN && ADDR_IN == IDX_CONTROL
		&& WDATA_IN[BIT_RESTART] |=> AN_RESTART_OUT ##1 !AN_RESTART_OUT)
		else $error("restart pulse wrong");
	chk_pause_idle: assert property (!AN_COMPLETE_IN || !AN_ENABLE_OUT
		|=> PAUSE_MODE_OUT == ANRS_PAUSE_NONE) else $error("pause adopted before completion");
	chk_advert_gate: assert property (!AN_ENABLE_OUT |=> ADVERT_WORD_OUT == 16'h0000)
		else $error("advert used while disabled");
endmodule : anrs_regs_assertions

bind anrs_regs anrs_regs_assertions u_chk (.MCLK_IN, .RST_N_IN, .ADDR_IN, .WDATA_IN,
	.WR_IN, .RD_IN, .RDATA_OUT, .PARTNER_VALID_IN, .PD_FAULT_IN, .AN_COMPLETE_IN,
	.ADVERT_WORD_OUT, .AN_ENABLE_OUT, .AN_RESTART_OUT, .PAUSE_MODE_OUT);

// *** tb/anrs_link_partner.sv ***
// model: remote link partner plus arbiter status seen by the register set
// assumes: the bench calls its tasks; everything moves on the system clock
`timescale 1ns/10ps
module anrs_link_partner (
	input  wire logic        clk_in,
	output logic      [15:0] word_out,
	output logic             valid_out,
	output logic             pd_fault_out,
	output logic             complete_out
);
	initial begin
		word_out     = 16'h0000;
		valid_out    = 1'b0;
		pd_fault_out = 1'b0;
		complete_out = 1'b0;
	end
	// word is only meaningful beside valid; afterwards it shows the inverse
	task automatic send_page(input logic [15:0] abil);
		@(posedge clk_in);
		word_out  <= {abil[15:5], 5'h01};
		valid_out <= 1'b1;
		@(posedge clk_in);
		valid_out <= 1'b0;
		word_out  <= ~{abil[15:5], 5'h01};
	endtask : send_page
	task automatic pd_pulse();
		@(posedge clk_in);
		pd_fault_out <= 1'b1;
		@(posedge clk_in);
		pd_fault_out <= 1'b0;
	endtask : pd_pulse
	task automatic set_complete(input logic v);
		@(posedge clk_in);
		complete_out <= v;
	endtask : set_complete
endmodule : anrs_link_partner

// *** tb/anrs_regs_tb_top.sv ***
// bench: random and corner stimulus on the register set, self-checking
// assumes: link partner model in its own file; checker bound separately
`timescale 1ns/10ps
module anrs_regs_tb_top;
	import anrs_pkg::*;
	logic                 mclk, rst_n, wr_stb, rd_stb, lp_valid, pd, cmpl;
	logic                 an_en, restart, spd, fdx, irq;
	logic [ADDR_W-1:0]    addr;
	logic [DATA_W-1:0]    wdata, rdata, lp_word, adv_word, got, w, a;
	logic [STRAP_W-1:0]   strap;
	anrs_pause_type       pause;
	int                   mismatches, cmp_count, seed;

	anrs_regs dut (.MCLK_IN(mclk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
		.WR_IN(wr_stb), .RD_IN(rd_stb), .RDATA_OUT(rdata), .MODE_STRAP_IN(strap),
		.PARTNER_WORD_IN(lp_word), .PARTNER_VALID_IN(lp_valid), .PD_FAULT_IN(pd),
		.AN_COMPLETE_IN(cmpl), .ADVERT_WORD_OUT(adv_word), .AN_ENABLE_OUT(an_en),
		.AN_RESTART_OUT(restart), .SPEED_100_OUT(spd), .FULL_DUPLEX_OUT(fdx),
		.PAUSE_MODE_OUT(pause), .IRQ_OUT(irq));
	anrs_link_partner lp (.clk_in(mclk), .word_out(lp_word), .valid_out(lp_valid),
		.pd_fault_out(pd), .complete_out(cmpl));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// ==========================================================
	// expectations
	function automatic logic [15:0] exp_lp(input logic [15:0] v);
		return (v & 16'h25e0) | 16'h4001;
	endfunction : exp_lp
	function automatic anrs_pause_type exp_pause(input logic [15:0] x, input logic [15:0] y);
		if (x[10] && y[10]) return ANRS_PAUSE_SYM;
		if (x[11]) return ANRS_PAUSE_ASYM;
		return ANRS_PAUSE_NONE;
	endfunction : exp_pause
	function automatic logic [1:0] exp_speed(input logic [15:0] x, input logic [15:0] y);
		logic [3:0] c;
		c = x[8:5] & y[8:5];
		if (c[3]) return 2'b11;
		if (c[2]) return 2'b10;
		if (c[1]) return 2'b01;
		return 2'b00;
	endfunction : exp_speed
	// ==========================================================
	// bus and check tasks
	task automatic wr(input logic [4:0] ad, input logic [15:0] d);
		@(posedge mclk);
		wr_stb <= 1'b1;
		addr   <= ad;
		wdata  <= d;
		@(posedge mclk);
		wr_stb <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [4:0] ad, output logic [15:0] d);
		@(posedge mclk);
		rd_stb <= 1'b1;
		addr   <= ad;
		@(posedge mclk);
		rd_stb <= 1'b0;
		#1 d = rdata;
	endtask : rd
	task automatic check(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : check
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		#200000;
		mismatches++;
		report_and_stop();
	end
	// ==========================================================
	// main sequence
	initial begin
		{rst_n, wr_stb, rd_stb, addr, wdata} = '0;
		mismatches = 0;
		cmp_count  = 0;
		seed  = $urandom(38);
		strap = $urandom;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (8) @(posedge mclk);
		rd(IDX_ADVERT, got);
		check(got, 16'h0081 | {strap[2], 1'b0, strap[1:0], 5'h00});
		rd(IDX_PARTNER, got);
		check(got, 16'h0001);
		for (int i = 0; i < 4; i++) begin
			w = $urandom;
			w[11:10] = i[1:0];
			wr(IDX_ADVERT, w);
			rd(IDX_ADVERT, got);
			check(got, w & 16'h2dff);
		end
		wr(5'h1f, $urandom);
		rd(5'h1f, got);
		check(got, 16'h0000);
		wr(IDX_PARTNER, 16'hffff);
		rd(IDX_PARTNER, got);
		check(got, 16'h0001);
		w = $urandom;
		lp.send_page(w);
		rd(IDX_PARTNER, got);
		check(got, exp_lp(w));
		rd(IDX_EXPANSION, got);
		check(got & 16'h001f, {12'h000, w[15], 3'b011});
		rd(IDX_EXPANSION, got);
		check(got & 16'h001f, {12'h000, w[15], 3'b001});
		lp.pd_pulse();
		rd(IDX_EXPANSION, got);
		check(got & 16'h001f, {11'h000, 1'b1, w[15], 3'b001});
		rd(IDX_EXPANSION, got);
		check(got & 16'h001f, {12'h000, w[15], 3'b001});
		// interrupt: raise, mask, clear
		wr(IDX_IRQ_MASK, 16'h0001);
		wr(IDX_IRQ_STAT, 16'h000f);
		check(irq, 1'b0);
		lp.send_page($urandom);
		@(posedge mclk);
		#1 check(irq, 1'b1);
		wr(IDX_IRQ_MASK, 16'h0000);
		check(irq, 1'b0);
		wr(IDX_IRQ_MASK, 16'h0001);
		check(irq, 1'b1);
		wr(IDX_IRQ_STAT, 16'h0001);
		check(irq, 1'b0);
		// resolution over every pause code
		for (int i = 0; i < 4; i++) begin
			a = ($urandom & 16'h01e0) | 16'h0021 | (i << 10);
			w = $urandom | 16'h0020;
			wr(IDX_ADVERT, a);
			lp.send_page(w);
			lp.set_complete(1'b1);
			repeat (3) @(posedge mclk);
			#1 check(pause, exp_pause(a, w));
			check({spd, fdx}, exp_speed(a, w));
			check(adv_word, a);
			lp.set_complete(1'b0);
		end
		// page received and completion edge events are sticky in the status word
		rd(IDX_IRQ_STAT, got);
		check(got & 16'h0007, 16'h0005);
		wr(IDX_CONTROL, 16'h0100);
		repeat (2) @(posedge mclk);
		#1 check({an_en, spd, fdx, adv_word}, {3'b001, 16'h0000});
		wr(IDX_CONTROL, 16'h3000);
		repeat (2) @(posedge mclk);
		#1 check({an_en, adv_word}, {1'b1, a});
		wr(IDX_CONTROL, 16'h1200);
		check(restart, 1'b1);
		@(posedge mclk);
		#1 check(restart, 1'b0);
		rd(IDX_CONTROL, got);
		check(got & 16'h0200, 16'h0000);
		rd(IDX_PARTNER, got);
		check(got, 16'h0001);
		// soft reset reloads the straps and the control defaults
		wr(IDX_ADVERT, 16'h2dff);
		wr(IDX_CONTROL, 16'h8000);
		rd(IDX_ADVERT, got);
		check(got, 16'h0081 | {strap[2], 1'b0, strap[1:0], 5'h00});
		rd(IDX_CONTROL, got);
		check(got, 16'h3100);
		report_and_stop();
	end
endmodule : anrs_regs_tb_top
